// ===== rtl/drs_pkg.sv
/*
 * Package for the diagnostic routine sequencer: routine codes, parameter
 * codes, display codes, timing counts and the request/result carriers.
 * Assumes a single 50 MHz system clock.
 */
package drs_pkg;
    localparam int CLK_MHZ = 50;
    localparam int TICK_US = 128;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [12:0] TICK_LAST = 13'(TICK_CYC - 1);

    localparam logic [7:0] RTN_DIFF_CNT = 8'h2E;
    localparam logic [7:0] RTN_LIN_MODE = 8'h2F;
    localparam logic [7:0] RTN_CYL_DET = 8'h30;
    localparam logic [7:0] RTN_POS_CHAN = 8'h31;
    localparam logic [7:0] RTN_COMM_REGS = 8'h34;
    localparam logic [7:0] RTN_CS_CHECK = 8'h35;
    localparam logic [7:0] RTN_DC_ONE = 8'h36;
    localparam logic [7:0] RTN_DC_TWO = 8'h37;
    localparam logic [7:0] RTN_IO_WRAP = 8'h38;
    localparam logic [7:0] RTN_IF_FULL = 8'h39;
    localparam logic [7:0] RTN_SER_BRD = 8'h3A;
    localparam logic [7:0] RTN_RW_SAFE = 8'h3B;
    localparam logic [7:0] RTN_CONTROL_INPUT_REGISTER_ROT = 8'h3D;

    localparam logic [7:0] PRM_PARTIAL = 8'h00;
    localparam logic [7:0] PRM_STOP_ERR = 8'hFE;
    localparam logic [7:0] PRM_SINGLE = 8'hFF;

    localparam logic [7:0] DISP_REFUSED = 8'hEE;
    localparam logic [7:0] DISP_PASS = 8'h00;
    localparam logic [7:0] ERR_DIFF_CNT = 8'h61;
    localparam logic [7:0] ERR_LIN_MODE = 8'h62;
    localparam logic [7:0] ERR_CONTROL_INPUT_REGISTER = 8'h63;
    localparam logic [7:0] ERR_CS = 8'h64;
    localparam logic [7:0] ERR_PARITY = 8'h65;
    localparam logic [7:0] ERR_BOARD = 8'h66;

    localparam logic [15:0] CS_EXPECT_ONE = 16'h0000;
    localparam logic [15:0] CS_EXPECT_TWO = 16'h0000;
    localparam int INIT_LIST_LEN = 4;

    typedef struct packed {
        logic valid;
        logic from_host;
        logic [7:0] code;
        logic [7:0] param;
    } drs_req_t;

    typedef struct packed {
        logic [7:0] pattern;
        logic odd_parity;
    } drs_probe_t;

    typedef struct packed {
        logic [15:0] sum_one;
        logic [15:0] sum_two;
        logic sums_ready;
    } drs_cs_t;
endpackage

// ===== rtl/drs_sequencer.sv
/*
 * Diagnostic routine sequencer: decodes routine code and parameter, runs
 * board checks one step per clock, repeats with a 128 us delay tick.
 * Assumes board readbacks return in the same cycle as the probe drive
 * and that control store checksums arrive on the checksum port.
 */
`timescale 1ns/1ps
module drs_sequencer (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire drs_pkg::drs_req_t REQ,
    input wire logic LOCAL_MODE,
    input wire logic DIAG_MODE,
    input wire logic ONLINE,
    input wire logic INIT_DONE,
    input wire logic ABORT,
    input wire logic [7:0] DIFF_CNT_RD,
    input wire logic LIN_MODE_RD,
    input wire logic [7:0] CONTROL_INPUT_REGISTER_RD,
    input wire logic PARITY_RD,
    input wire drs_pkg::drs_cs_t CS_SUMS,
    input wire logic BOARD_OK,
    output logic [7:0] DIFF_CNT_WR,
    output logic LIN_MODE_WR,
    output logic [7:0] CONTROL_INPUT_REGISTER_WR,
    output drs_pkg::drs_probe_t PROBE,
    output logic [7:0] BOARD_SEL,
    output logic BUSY,
    output logic DONE,
    output logic ERROR,
    output logic [7:0] DATA_DISPLAY,
    output logic [7:0] ROUTINE_DISPLAY
);
    import drs_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_RUN, S_CHECK, S_DELAY, S_HALT} drs_state_t;

    function automatic logic param_ok(input logic [7:0] code, input logic [7:0] prm);
        logic ok;
        ok = 1'b1;
        if (code == RTN_CS_CHECK || (code >= RTN_DC_ONE && code <= RTN_RW_SAFE)) begin
            ok = 1'b1;
        end else if (prm == PRM_STOP_ERR) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic code_ok(input logic [7:0] code);
        return code == RTN_DIFF_CNT || code == RTN_LIN_MODE || code == RTN_CYL_DET
            || code == RTN_POS_CHAN || code == RTN_COMM_REGS || code == RTN_CS_CHECK
            || code == RTN_DC_ONE || code == RTN_DC_TWO || code == RTN_IO_WRAP
            || code == RTN_IF_FULL || code == RTN_SER_BRD || code == RTN_RW_SAFE
            || code == RTN_CONTROL_INPUT_REGISTER_ROT;
    endfunction

    function automatic logic [7:0] init_code(input logic [1:0] idx);
        logic [7:0] c;
        c = RTN_CYL_DET;
        unique case (idx)
            2'd0: c = RTN_CYL_DET;
            2'd1: c = RTN_POS_CHAN;
            2'd2: c = RTN_COMM_REGS;
            2'd3: c = RTN_DC_ONE;
        endcase
        return c;
    endfunction

    drs_state_t st_q, st_d;
    logic [7:0] code_q, code_d, prm_q, prm_d;
    logic [8:0] step_q, step_d;
    logic partial_q, partial_d, init_q, init_d;
    logic [1:0] init_idx_q, init_idx_d;
    logic [12:0] tick_q, tick_d;
    logic [7:0] wait_q, wait_d;
    logic fail_q, fail_d;
    logic busy_q, busy_d, done_q, done_d, err_q, err_d;
    logic [7:0] disp_q, disp_d, rdisp_q, rdisp_d;
    logic [7:0] dwr_q, dwr_d, cwr_q, cwr_d, sel_q, sel_d;
    logic lin_q, lin_d;
    drs_probe_t probe_q, probe_d;
    logic init_seen_q, init_seen_d;
    logic allowed, last_step, step_fail;
    logic [7:0] fail_code;

    // Diagnostic requests accepted from panel in local or host in diagnostic
    assign allowed = REQ.from_host ? DIAG_MODE : LOCAL_MODE;

    always_comb begin
        last_step = 1'b1;
        step_fail = 1'b0;
        fail_code = ERR_BOARD;
        unique case (code_q)
            RTN_DIFF_CNT: begin
                // Drive lags the step count by a step, so the last value is seen at 256
                last_step = step_q == 9'd256;
                step_fail = DIFF_CNT_RD != dwr_q;
                fail_code = ERR_DIFF_CNT;
            end
            RTN_LIN_MODE: begin
                last_step = step_q == 9'd2;
                step_fail = LIN_MODE_RD != lin_q;
                fail_code = ERR_LIN_MODE;
            end
            RTN_CONTROL_INPUT_REGISTER_ROT: begin
                last_step = step_q == 9'd8;
                step_fail = CONTROL_INPUT_REGISTER_RD != cwr_q;
                fail_code = ERR_CONTROL_INPUT_REGISTER;
            end
            RTN_CS_CHECK: begin
                last_step = CS_SUMS.sums_ready;
                step_fail = CS_SUMS.sums_ready && (CS_SUMS.sum_one != CS_EXPECT_ONE
                    || CS_SUMS.sum_two != CS_EXPECT_TWO);
                fail_code = ERR_CS;
            end
            RTN_IF_FULL: begin
                last_step = partial_q || step_q == 9'd256;
                step_fail = PARITY_RD != probe_q.odd_parity;
                fail_code = ERR_PARITY;
            end
            default: begin
                step_fail = !BOARD_OK;
            end
        endcase
    end

    always_comb begin
        st_d = st_q;
        code_d = code_q;
        prm_d = prm_q;
        step_d = step_q;
        partial_d = partial_q;
        init_d = init_q;
        init_idx_d = init_idx_q;
        tick_d = tick_q;
        wait_d = wait_q;
        fail_d = fail_q;
        busy_d = busy_q;
        done_d = 1'b0;
        err_d = err_q;
        disp_d = disp_q;
        rdisp_d = rdisp_q;
        init_seen_d = INIT_DONE;
        sel_d = code_q;
        dwr_d = step_q[7:0];
        cwr_d = 8'h01 << step_q[2:0];
        lin_d = !step_q[0];
        probe_d.pattern = partial_q ? 8'hA5 : step_q[7:0];
        probe_d.odd_parity = ^probe_d.pattern;
        unique case (st_q)
            S_IDLE, S_HALT: begin
                if (INIT_DONE && !init_seen_q) begin
                    init_d = 1'b1;
                    init_idx_d = 2'd0;
                    code_d = init_code(2'd0);
                    prm_d = PRM_SINGLE;
                    step_d = 9'd0;
                    fail_d = 1'b0;
                    err_d = 1'b0;
                    busy_d = 1'b1;
                    st_d = S_RUN;
                end else if (REQ.valid) begin
                    if (!allowed || !code_ok(REQ.code) || !param_ok(REQ.code, REQ.param)) begin
                        disp_d = DISP_REFUSED;
                    end else begin
                        code_d = REQ.code;
                        prm_d = REQ.param;
                        partial_d = REQ.code == RTN_IF_FULL && REQ.param == PRM_PARTIAL
                            && !ONLINE;
                        init_d = 1'b0;
                        step_d = 9'd0;
                        fail_d = 1'b0;
                        err_d = 1'b0;
                        disp_d = DISP_PASS;
                        rdisp_d = REQ.code;
                        busy_d = 1'b1;
                        st_d = S_RUN;
                    end
                end
            end
            S_RUN: begin
                if (step_q != 9'd0 && step_fail) begin
                    fail_d = 1'b1;
                    err_d = 1'b1;
                    disp_d = fail_code;
                end
                // First step only loads the drive flops; readback checked next
                if (step_q != 9'd0 && last_step) begin
                    st_d = S_CHECK;
                end else begin
                    step_d = step_q + 9'd1;
                end
            end
            S_CHECK: begin
                step_d = 9'd0;
                tick_d = 13'd0;
                wait_d = 8'd0;
                done_d = 1'b1;
                if (init_q) begin
                    if (init_idx_q == 2'(INIT_LIST_LEN - 1)) begin
                        init_d = 1'b0;
                        busy_d = 1'b0;
                        st_d = S_IDLE;
                    end else begin
                        init_idx_d = init_idx_q + 2'd1;
                        code_d = init_code(init_idx_q + 2'd1);
                        st_d = S_RUN;
                    end
                end else if (prm_q == PRM_SINGLE
                        || (prm_q == PRM_STOP_ERR && (fail_q || step_fail))) begin
                    busy_d = 1'b0;
                    st_d = S_HALT;
                end else if (partial_q) begin
                    busy_d = 1'b0;
                    st_d = S_HALT;
                end else begin
                    fail_d = 1'b0;
                    st_d = S_DELAY;
                end
            end
            S_DELAY: begin
                if (ABORT) begin
                    busy_d = 1'b0;
                    st_d = S_IDLE;
                end else if (wait_q == prm_q || prm_q == PRM_STOP_ERR) begin
                    st_d = S_RUN;
                end else if (tick_q == TICK_LAST) begin
                    tick_d = 13'd0;
                    wait_d = wait_q + 8'd1;
                end else begin
                    tick_d = tick_q + 13'd1;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_q <= S_IDLE;
            code_q <= 8'h00;
            prm_q <= 8'h00;
            step_q <= 9'd0;
            partial_q <= 1'b0;
            init_q <= 1'b0;
            init_idx_q <= 2'd0;
            tick_q <= 13'd0;
            wait_q <= 8'd0;
            fail_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            disp_q <= 8'h00;
            rdisp_q <= 8'h00;
            dwr_q <= 8'h00;
            cwr_q <= 8'h00;
            lin_q <= 1'b0;
            sel_q <= 8'h00;
            probe_q <= '0;
            init_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            code_q <= code_d;
            prm_q <= prm_d;
            step_q <= step_d;
            partial_q <= partial_d;
            init_q <= init_d;
            init_idx_q <= init_idx_d;
            tick_q <= tick_d;
            wait_q <= wait_d;
            fail_q <= fail_d;
            busy_q <= busy_d;
            done_q <= done_d;
            err_q <= err_d;
            disp_q <= disp_d;
            rdisp_q <= rdisp_d;
            dwr_q <= dwr_d;
            cwr_q <= cwr_d;
            lin_q <= lin_d;
            sel_q <= sel_d;
            probe_q <= probe_d;
            init_seen_q <= init_seen_d;
        end
    end

    assign DIFF_CNT_WR = dwr_q;
    assign LIN_MODE_WR = lin_q;
    assign CONTROL_INPUT_REGISTER_WR = cwr_q;
    assign PROBE = probe_q;
    assign BOARD_SEL = sel_q;
    assign BUSY = busy_q;
    assign DONE = done_q;
    assign ERROR = err_q;
    assign DATA_DISPLAY = disp_q;
    assign ROUTINE_DISPLAY = rdisp_q;

    property p_refuse;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_IDLE && REQ.valid && !allowed && !(INIT_DONE && !init_seen_q))
            |=> DATA_DISPLAY == DISP_REFUSED && !BUSY;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused request not shown");

    property p_single;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_CHECK && !init_q && prm_q == PRM_SINGLE) |=> st_q == S_HALT ##1 !BUSY;
    endproperty
    a_single: assert property (p_single) else $error("single cycle kept running");

    property p_delay_tick;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_DELAY && tick_q == TICK_LAST && wait_q != prm_q && !ABORT
            && prm_q != PRM_STOP_ERR) |=> wait_q == $past(wait_q) + 8'd1;
    endproperty
    a_delay_tick: assert property (p_delay_tick) else $error("delay tick not counted");

    property p_online_full;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_IDLE && REQ.valid && ONLINE) |=> !partial_q;
    endproperty
    a_online_full: assert property (p_online_full) else $error("partial test while online");

    sequence s_parity_bad;
        st_q == S_RUN && code_q == RTN_IF_FULL && step_q != 9'd0
            && PARITY_RD != probe_q.odd_parity;
    endsequence
    property p_parity;
        @(posedge REF_CLK) disable iff (!RST_N)
        s_parity_bad |=> ERROR && DATA_DISPLAY == ERR_PARITY;
    endproperty
    a_parity: assert property (p_parity) else $error("parity fault not reported");

    property p_stop_err;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_CHECK && !init_q && prm_q == PRM_STOP_ERR && fail_q) |=> st_q == S_HALT;
    endproperty
    a_stop_err: assert property (p_stop_err) else $error("no halt on error");

    property p_init;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_IDLE && INIT_DONE && !init_seen_q) |=> BUSY && code_q == RTN_CYL_DET;
    endproperty
    a_init: assert property (p_init) else $error("init checks not started");

    property p_walk;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_q == S_RUN && code_q == RTN_CONTROL_INPUT_REGISTER_ROT && step_q == 9'd3) |=> CONTROL_INPUT_REGISTER_WR == 8'h08;
    endproperty
    a_walk: assert property (p_walk) else $error("walking bit wrong");
endmodule

// ===== testbench/diag_routine_sequencer_test.sv
/*
 * Self-checking bench for the diagnostic routine sequencer.
 * Assumes drs_pkg and the board model; the driver queues expected
 * results and the monitor compares them as passes end or are refused.
 */
`timescale 1ns/1ps
module diag_routine_sequencer_test;
    import drs_pkg::*;
    logic REF_CLK, RST_N, LOCAL_MODE, DIAG_MODE, ONLINE, INIT_DONE, ABORT, fault, log_on;
    logic LIN_MODE_RD, PARITY_RD, BOARD_OK, LIN_MODE_WR, BUSY, DONE, ERROR, req_q, done_q;
    logic busy_p = 1'b0;
    logic [7:0] DIFF_CNT_RD, CONTROL_INPUT_REGISTER_RD, DIFF_CNT_WR, CONTROL_INPUT_REGISTER_WR, BOARD_SEL, seen_control_input_register;
    logic [7:0] DATA_DISPLAY, ROUTINE_DISPLAY;
    logic [255:0] seen_pat, seen_cnt;
    logic [1:0] seen_lin;
    drs_req_t REQ;
    drs_cs_t CS_SUMS;
    drs_probe_t PROBE;
    logic [8:0] exp_q[$];
    logic [7:0] sel_log[$];
    int done_at[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_done = 0;
    int gap[3];
    localparam int LIMIT = 90000;
    localparam logic [7:0] RUN_CODE[7] = '{RTN_DIFF_CNT, RTN_LIN_MODE, RTN_CONTROL_INPUT_REGISTER_ROT,
        RTN_CS_CHECK, RTN_SER_BRD, RTN_RW_SAFE, RTN_IF_FULL};
    localparam logic [7:0] RUN_ERR[7] = '{ERR_DIFF_CNT, ERR_LIN_MODE, ERR_CONTROL_INPUT_REGISTER, ERR_CS,
        ERR_BOARD, ERR_BOARD, ERR_PARITY};
    localparam logic [7:0] INIT_CODES[4] = '{RTN_CYL_DET, RTN_POS_CHAN, RTN_COMM_REGS,
        RTN_DC_ONE};

    drs_sequencer i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .REQ(REQ),
        .LOCAL_MODE(LOCAL_MODE), .DIAG_MODE(DIAG_MODE), .ONLINE(ONLINE),
        .INIT_DONE(INIT_DONE), .ABORT(ABORT), .DIFF_CNT_RD(DIFF_CNT_RD),
        .LIN_MODE_RD(LIN_MODE_RD), .CONTROL_INPUT_REGISTER_RD(CONTROL_INPUT_REGISTER_RD), .PARITY_RD(PARITY_RD),
        .CS_SUMS(CS_SUMS), .BOARD_OK(BOARD_OK), .DIFF_CNT_WR(DIFF_CNT_WR),
        .LIN_MODE_WR(LIN_MODE_WR), .CONTROL_INPUT_REGISTER_WR(CONTROL_INPUT_REGISTER_WR), .PROBE(PROBE),
        .BOARD_SEL(BOARD_SEL), .BUSY(BUSY), .DONE(DONE), .ERROR(ERROR),
        .DATA_DISPLAY(DATA_DISPLAY), .ROUTINE_DISPLAY(ROUTINE_DISPLAY));
    drs_board_model i_board (.fault(fault), .diff_cnt_wr(DIFF_CNT_WR),
        .lin_mode_wr(LIN_MODE_WR), .control_input_register_wr(CONTROL_INPUT_REGISTER_WR), .probe(PROBE),
        .diff_cnt_rd(DIFF_CNT_RD), .lin_mode_rd(LIN_MODE_RD), .control_input_register_rd(CONTROL_INPUT_REGISTER_RD),
        .parity_rd(PARITY_RD), .cs_sums(CS_SUMS), .board_ok(BOARD_OK));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge REF_CLK);
            #1;
        end
    endtask

    task automatic send(input logic host, input logic [7:0] c, input logic [7:0] p);
        REQ = '{1'b1, host, c, p};
        step(1);
        REQ.valid = 1'b0;
        step(1);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 30000 && BUSY !== 1'b0; n++) begin
            step(1);
        end
        step(2);
        chk("busy", 32'h0, {31'h0, BUSY});
    endtask

    task automatic wait_done(input int k);
        for (int n = 0; n < 30000 && n_done < k; n++) begin
            step(1);
        end
        step(2);
    endtask

    task automatic clear_seen();
        seen_pat = '0;
        seen_cnt = '0;
        seen_lin = '0;
        seen_control_input_register = '0;
    endtask

    task automatic run(input logic [7:0] c, input logic [7:0] p, input logic f,
        input logic [8:0] e);
        int d0;
        d0 = n_done;
        fault = f;
        clear_seen();
        exp_q.push_back(e);
        send(1'b0, c, p);
        wait_idle();
        chk("pass count", d0 + 1, n_done);
        chk("routine display", c, ROUTINE_DISPLAY);
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    // Monitor: samples on the edge, so registered outputs are settled
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            final_report();
        end
        if (RST_N === 1'b1) begin
            if (done_q && exp_q.size() > 0) begin
                chk("pass result", 32'(exp_q.pop_front()), {23'h0, ERROR, DATA_DISPLAY});
            end
            if (req_q && BUSY !== 1'b1 && exp_q.size() > 0) begin
                chk("refused", 32'(exp_q.pop_front()), {23'h0, ERROR, DATA_DISPLAY});
            end
            if (DONE === 1'b1) begin
                n_done++;
                done_at.push_back(cyc);
            end
            // First busy cycle still shows the previous run's drive values
            if (BUSY === 1'b1 && busy_p) begin
                chk("probe parity", {31'h0, ^PROBE.pattern}, {31'h0, PROBE.odd_parity});
                seen_pat[PROBE.pattern] = 1'b1;
                seen_cnt[DIFF_CNT_WR] = 1'b1;
                seen_lin[LIN_MODE_WR] = 1'b1;
                if ($onehot(CONTROL_INPUT_REGISTER_WR)) begin
                    seen_control_input_register |= CONTROL_INPUT_REGISTER_WR;
                end
            end
            if (log_on && BUSY === 1'b1 && busy_p
                    && (sel_log.size() == 0 || sel_log[$] != BOARD_SEL)) begin
                sel_log.push_back(BOARD_SEL);
            end
        end
        done_q = RST_N === 1'b1 && DONE === 1'b1;
        busy_p = RST_N === 1'b1 && BUSY === 1'b1;
        req_q = RST_N === 1'b1 && REQ.valid === 1'b1 && BUSY !== 1'b1;
    end

    initial begin
        RST_N = 1'b0;
        REQ = '0;
        {LOCAL_MODE, DIAG_MODE, ONLINE, INIT_DONE, ABORT, fault, log_on} = 7'h00;
        void'($urandom(64141));
        step(6);
        RST_N = 1'b1;
        chk("reset outputs", 32'h0, {21'h0, BUSY, DONE, ERROR, DATA_DISPLAY});
        repeat (4) exp_q.push_back({1'b0, DISP_REFUSED});
        send(1'b0, RTN_IF_FULL, PRM_SINGLE);
        send(1'b1, RTN_IF_FULL, PRM_SINGLE);
        LOCAL_MODE = 1'b1;
        send(1'b0, 8'($urandom_range(255, 64)), 8'($urandom_range(255, 0)));
        send(1'b0, RTN_DIFF_CNT, PRM_STOP_ERR);
        $display("test refusals done");
        for (int i = 0; i < 7; i++) begin
            for (int f = 0; f < 2; f++) begin
                run(RUN_CODE[i], PRM_SINGLE, f[0], f[0] ? {1'b1, RUN_ERR[i]} : 9'h000);
                if (f == 0) begin
                    case (i)
                        0: chk("counter values", 256, $countones(seen_cnt));
                        1: chk("linear bit states", 2'b11, seen_lin);
                        2: chk("walking bits", 8'hFF, seen_control_input_register);
                        6: chk("parity patterns", 256, $countones(seen_pat));
                        default: ;
                    endcase
                end
            end
        end
        $display("test single cycle routines done");
        run(RTN_IF_FULL, PRM_PARTIAL, 1'b0, 9'h000);
        chk("partial patterns", 1, $countones(seen_pat));
        run(RTN_IF_FULL, PRM_STOP_ERR, 1'b1, {1'b1, ERR_PARITY});
        fault = 1'b0;
        ONLINE = 1'b1;
        DIAG_MODE = 1'b1;
        clear_seen();
        exp_q.push_back(9'h000);
        send(1'b1, RTN_IF_FULL, PRM_PARTIAL);
        wait_done(n_done + 1);
        chk("online patterns", 256, $countones(seen_pat));
        // Forced full run may free-run, so end it by reset
        RST_N = 1'b0;
        step(6);
        RST_N = 1'b1;
        ONLINE = 1'b0;
        $display("test partial and online done");
        for (int p = 1; p < 3; p++) begin
            int d0;
            d0 = n_done;
            repeat (3) exp_q.push_back(9'h000);
            send(1'b0, RTN_IF_FULL, 8'(p));
            wait_done(d0 + 3);
            gap[p] = done_at[d0 + 2] - done_at[d0 + 1];
            ABORT = 1'b1;
            wait_idle();
            ABORT = 1'b0;
        end
        chk("delay step", TICK_CYC, gap[2] - gap[1]);
        chk("delay after pass", 1, gap[1] > TICK_CYC + 256);
        $display("test repeat delay done");
        sel_log.delete();
        log_on = 1'b1;
        INIT_DONE = 1'b1;
        for (int n = 0; n < 30000 && sel_log.size() < INIT_LIST_LEN; n++) begin
            step(1);
        end
        wait_idle();
        for (int i = 0; i < INIT_LIST_LEN; i++) begin
            chk("init routine", INIT_CODES[i], sel_log[i]);
        end
        $display("test initialization list done");
        chk("pending results", 0, exp_q.size());
        final_report();
    end
endmodule

// ===== testbench/drs_board_model.sv
/*
 * Board model for the diagnostic routine sequencer: loops back what the
 * sequencer writes and reports clean checksums and board status.
 * Assumes readbacks are sampled in the same cycle as the writes; the
 * fault input corrupts every readback but sum_two at once so each routine can fail.
 */
`timescale 1ns/1ps
module drs_board_model
    import drs_pkg::*;
(
    input wire logic fault,
    input wire logic [7:0] diff_cnt_wr,
    input wire logic lin_mode_wr,
    input wire logic [7:0] control_input_register_wr,
    input wire drs_pkg::drs_probe_t probe,
    output logic [7:0] diff_cnt_rd,
    output logic lin_mode_rd,
    output logic [7:0] control_input_register_rd,
    output logic parity_rd,
    output drs_pkg::drs_cs_t cs_sums,
    output logic board_ok
);
    always_comb begin
        diff_cnt_rd = diff_cnt_wr ^ {7'h00, fault};
        lin_mode_rd = lin_mode_wr ^ fault;
        control_input_register_rd = control_input_register_wr ^ {7'h00, fault};
        // Parity line looped back from the probe's driven odd parity bit
        parity_rd = probe.odd_parity ^ fault;
        cs_sums.sum_one = CS_EXPECT_ONE ^ {15'h0000, fault};
        cs_sums.sum_two = CS_EXPECT_TWO;
        cs_sums.sums_ready = 1'b1;
        board_ok = ~fault;
    end
endmodule
